// ### logic/irq_ctrl_pkg.sv
// Package: register map, field positions and types for the interrupt block
package irq_ctrl_pkg;
   // ****************************************************************
   // Register byte addresses on the register bus
   // ****************************************************************
   localparam logic [7:0] ADDR_CPU_STATUS_WORD = 8'h00;
   localparam logic [7:0] ADDR_CORE_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_INT_CONTROL_ONE = 8'h08;
   localparam logic [7:0] ADDR_INT_CONTROL_TWO = 8'h0C;
   localparam logic [7:0] ADDR_REQ_FLAGS_FIRST = 8'h10;
   localparam logic [7:0] ADDR_REQ_ENABLES_FIRST = 8'h14;
   localparam logic [7:0] ADDR_REQ_PRIO_BASE = 8'h18;
   localparam logic [7:0] ADDR_PENDING_VECTOR_STATUS = 8'h28;
   localparam int NUM_PRIO_REGS = 4;
   localparam int SRC_PER_PRIO_REG = 4;
   localparam int PRIO_SLOT = 4;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CPU_LEVEL_LSB = 5;          // cpu_status_word 7:5
   localparam int CPU_TOP_BIT = 3;            // core_control bit 3
   localparam int NESTING_DISABLE_BIT = 15;
   localparam int ACC_A_OVF_BIT = 14;
   localparam int ACC_B_OVF_BIT = 13;
   localparam int ACC_A_CAT_BIT = 12;
   localparam int ACC_B_CAT_BIT = 11;
   localparam int ACC_A_OVF_TE_BIT = 10;
   localparam int ACC_B_OVF_TE_BIT = 9;
   localparam int CAT_TE_BIT = 8;
   localparam int BAD_SHIFT_BIT = 7;
   localparam int ARITH_BIT = 6;
   localparam int DMA_FAULT_BIT = 5;
   localparam int MATH_TRAP_BIT = 4;
   localparam int ADDR_FAULT_BIT = 3;
   localparam int STACK_FAULT_BIT = 2;
   localparam int CLOCK_LOSS_BIT = 1;
   localparam int ALT_VECTOR_BIT = 15;        // interrupt_control_two
   localparam int NUM_EXT_PINS = 5;
   localparam logic [6:0] FIRST_USER_VECTOR = 7'h08;
   localparam logic [15:0] RESET_REG16 = 16'h0000;
   localparam logic [3:0] USER_LEVEL_LIMIT = 4'h7;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic acc_a_overflow;
      logic acc_b_overflow;
      logic acc_a_catastrophic;
      logic acc_b_catastrophic;
      logic bad_shift;
      logic arith_error;
      logic dma_fault;
      logic address_fault;
      logic stack_fault;
      logic clock_loss;
   } trap_events_t;

   typedef struct packed {
      logic valid;
      logic [6:0] vector;
      logic [3:0] level;
   } pending_t;
endpackage

// ### logic/irq_priority_ctrl.sv
// Interrupt priority, request flags and trap status block with AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Each source owns a flag; hardware sets it, only software clears it.
// - A source with its enable clear is never taken; flag still sets.
// - Each user source has a 3-bit programmable priority, levels 0..7.
// - Pending vector latched into 7-bit field, its level into 4-bit field.
// - Flags, enables, priorities in index order; source 0 at bit 0, 2:0.
// - CPU level low three bits at status word 7:5, software writable.
// - Fourth level bit at core control bit 3 cannot be set by software.
// - Level is top bit over 3-bit field; 111 is 7 or 15, users off.
// - With the top bit set all user interrupts are blocked.
// - While nesting is disabled the 3-bit level field ignores writes.
// - Trap flags: A overflow 14, B overflow 13, A/B catastrophic 12, 11.
// - Trap enables: A overflow 10, B overflow 9, catastrophic 8.
// - Math trap cause: bit 7 bad shift, bit 6 arithmetic error.
// - Bits 3, 2, 1 record address, stack, clock loss traps; bit 0 zero.
// - Control two sets external pin edge polarity and alternate table.
module irq_priority_ctrl #(
   parameter int NUM_SRC = 16
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // AXI4-Lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Request sources and traps
   input wire logic [NUM_SRC-1:0] SRC_REQ,
   input wire logic [irq_ctrl_pkg::NUM_EXT_PINS-1:0] EXT_PIN,
   input wire irq_ctrl_pkg::trap_events_t TRAP_EVENT,
   // Processor core side
   input wire logic CORE_ACK,
   input wire logic CORE_TRAP_ENTER,
   output irq_ctrl_pkg::pending_t PENDING,
   output logic [3:0] CPU_LEVEL,
   output logic ALT_VECTOR,
   output logic TRAP_PENDING,
   output logic [irq_ctrl_pkg::NUM_EXT_PINS-1:0] EXT_EDGE
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [2:0] cpu_priority_level;
   logic cpu_priority_top_bit;
   logic [15:0] interrupt_control_one;
   logic [15:0] interrupt_control_two;
   logic [NUM_SRC-1:0] request_flags_first;
   logic [NUM_SRC-1:0] request_enables_first;
   logic [2:0] prio [NUM_SRC];
   irq_ctrl_pkg::pending_t pending_vector_status;
   logic [irq_ctrl_pkg::NUM_EXT_PINS-1:0] pin_meta, pin_sync, pin_last;

   // Bus holding registers
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] next_rdata;
   logic rd_hit;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) res[7:0] = data[7:0];
      if (strb[1]) res[15:8] = data[15:8];
      return res;
   endfunction

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
   assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

   // Address and data are caught independently, either order
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response; unmapped or read-only address answers SLVERR
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= irq_ctrl_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= addr_ok(aw_addr) ? irq_ctrl_pkg::RESP_OKAY
                                         : irq_ctrl_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   function automatic logic addr_ok(input logic [7:0] a);
      return (a == irq_ctrl_pkg::ADDR_CPU_STATUS_WORD) ||
             (a == irq_ctrl_pkg::ADDR_CORE_CONTROL) ||
             (a == irq_ctrl_pkg::ADDR_INT_CONTROL_ONE) ||
             (a == irq_ctrl_pkg::ADDR_INT_CONTROL_TWO) ||
             (a == irq_ctrl_pkg::ADDR_REQ_FLAGS_FIRST) ||
             (a == irq_ctrl_pkg::ADDR_REQ_ENABLES_FIRST) ||
             ((a >= irq_ctrl_pkg::ADDR_REQ_PRIO_BASE) &&
              (a < irq_ctrl_pkg::ADDR_PENDING_VECTOR_STATUS) &&
              (a[1:0] == 2'b00));
   endfunction

   // ****************************************************************
   // CPU priority level
   // ****************************************************************
   // Field follows software unless nesting is disabled; the core's
   // acknowledge raises it to the taken level and wins over software
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         cpu_priority_level <= 3'b000;
      end else if (CORE_ACK && PENDING.valid) begin
         cpu_priority_level <= PENDING.level[2:0];
      end else if (wr_fire && w_strb[0] &&
                   aw_addr == irq_ctrl_pkg::ADDR_CPU_STATUS_WORD &&
                   !interrupt_control_one[
                      irq_ctrl_pkg::NESTING_DISABLE_BIT]) begin
         cpu_priority_level <=
            w_data[irq_ctrl_pkg::CPU_LEVEL_LSB +: 3];
      end
   end

   // Top bit: only trap entry sets it; a software write can clear only
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         cpu_priority_top_bit <= 1'b0;
      end else if (CORE_TRAP_ENTER) begin
         cpu_priority_top_bit <= 1'b1;
      end else if (wr_fire &&
                   aw_addr == irq_ctrl_pkg::ADDR_CORE_CONTROL &&
                   w_strb[0] &&
                   !w_data[irq_ctrl_pkg::CPU_TOP_BIT]) begin
         cpu_priority_top_bit <= 1'b0;
      end
   end

   assign CPU_LEVEL = {cpu_priority_top_bit, cpu_priority_level};

   // ****************************************************************
   // Control one: nesting disable, trap flags, enables, causes
   // ****************************************************************
   logic [15:0] trap_set;
   logic math_event;

   // Overflows only count as traps while their enable bit is set
   always_comb begin
      trap_set = '0;
      trap_set[irq_ctrl_pkg::ACC_A_OVF_BIT] = TRAP_EVENT.acc_a_overflow &&
         interrupt_control_one[irq_ctrl_pkg::ACC_A_OVF_TE_BIT];
      trap_set[irq_ctrl_pkg::ACC_B_OVF_BIT] = TRAP_EVENT.acc_b_overflow &&
         interrupt_control_one[irq_ctrl_pkg::ACC_B_OVF_TE_BIT];
      trap_set[irq_ctrl_pkg::ACC_A_CAT_BIT] =
         TRAP_EVENT.acc_a_catastrophic &&
         interrupt_control_one[irq_ctrl_pkg::CAT_TE_BIT];
      trap_set[irq_ctrl_pkg::ACC_B_CAT_BIT] =
         TRAP_EVENT.acc_b_catastrophic &&
         interrupt_control_one[irq_ctrl_pkg::CAT_TE_BIT];
      trap_set[irq_ctrl_pkg::BAD_SHIFT_BIT] = TRAP_EVENT.bad_shift;
      trap_set[irq_ctrl_pkg::ARITH_BIT] = TRAP_EVENT.arith_error;
      trap_set[irq_ctrl_pkg::DMA_FAULT_BIT] = TRAP_EVENT.dma_fault;
      trap_set[irq_ctrl_pkg::ADDR_FAULT_BIT] = TRAP_EVENT.address_fault;
      trap_set[irq_ctrl_pkg::STACK_FAULT_BIT] = TRAP_EVENT.stack_fault;
      trap_set[irq_ctrl_pkg::CLOCK_LOSS_BIT] = TRAP_EVENT.clock_loss;
      math_event = |trap_set[irq_ctrl_pkg::ACC_A_OVF_BIT:
                             irq_ctrl_pkg::ARITH_BIT];
      trap_set[irq_ctrl_pkg::MATH_TRAP_BIT] = math_event;
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         interrupt_control_one <= irq_ctrl_pkg::RESET_REG16;
      end else begin
         if (wr_fire && aw_addr == irq_ctrl_pkg::ADDR_INT_CONTROL_ONE) begin
            interrupt_control_one <= (merge16(interrupt_control_one,
               w_data, w_strb) | trap_set) & 16'hFFFE;
         end else begin
            interrupt_control_one <= interrupt_control_one | trap_set;
         end
      end
   end

   // Any trap status bit set asks the core for a trap
   assign TRAP_PENDING = |interrupt_control_one[
      irq_ctrl_pkg::ACC_A_OVF_BIT:irq_ctrl_pkg::ACC_B_CAT_BIT] ||
      |interrupt_control_one[irq_ctrl_pkg::DMA_FAULT_BIT:
                             irq_ctrl_pkg::CLOCK_LOSS_BIT];

   // ****************************************************************
   // Control two and external pins
   // ****************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         interrupt_control_two <= irq_ctrl_pkg::RESET_REG16;
      end else if (wr_fire &&
                   aw_addr == irq_ctrl_pkg::ADDR_INT_CONTROL_TWO) begin
         interrupt_control_two <= merge16(interrupt_control_two, w_data,
            w_strb) & 16'h801F;
      end
   end

   assign ALT_VECTOR = interrupt_control_two[irq_ctrl_pkg::ALT_VECTOR_BIT];

   // Pins are asynchronous; two flops before any edge logic sees them
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_last <= '0;
      end else begin
         pin_meta <= EXT_PIN;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   // Polarity bit one picks falling edges, zero rising edges
   always_comb begin
      for (int p = 0; p < irq_ctrl_pkg::NUM_EXT_PINS; p++) begin
         EXT_EDGE[p] = interrupt_control_two[p] ?
            (pin_last[p] && !pin_sync[p]) :
            (!pin_last[p] && pin_sync[p]);
      end
   end

   // ****************************************************************
   // Request flags, enables, priorities
   // ****************************************************************
   logic [NUM_SRC-1:0] src_set;
   always_comb begin
      src_set = SRC_REQ;
      src_set[0] = SRC_REQ[0] || EXT_EDGE[0];   // Pin 0 is source 0
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         request_flags_first <= '0;
      end else if (wr_fire &&
                   aw_addr == irq_ctrl_pkg::ADDR_REQ_FLAGS_FIRST) begin
         request_flags_first <= merge16(request_flags_first, w_data,
                                        w_strb) | src_set;
      end else begin
         request_flags_first <= request_flags_first | src_set;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         request_enables_first <= '0;
      end else if (wr_fire &&
                   aw_addr == irq_ctrl_pkg::ADDR_REQ_ENABLES_FIRST) begin
         request_enables_first <= merge16(request_enables_first, w_data,
                                          w_strb);
      end
   end

   // Four sources per priority register, 3 bits in each nibble
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         for (int s = 0; s < NUM_SRC; s++) prio[s] <= 3'b000;
      end else if (wr_fire) begin
         for (int s = 0; s < NUM_SRC; s++) begin
            if (aw_addr == irq_ctrl_pkg::ADDR_REQ_PRIO_BASE +
                8'((s / irq_ctrl_pkg::SRC_PER_PRIO_REG) * 4) &&
                w_strb[(s % irq_ctrl_pkg::SRC_PER_PRIO_REG) / 2]) begin
               prio[s] <= w_data[(s % irq_ctrl_pkg::SRC_PER_PRIO_REG) *
                                 irq_ctrl_pkg::PRIO_SLOT +: 3];
            end
         end
      end
   end

   // ****************************************************************
   // Arbitration and pending vector latch
   // ****************************************************************
   irq_ctrl_pkg::pending_t next_pending;
   always_comb begin
      next_pending = '0;
      for (int s = 0; s < NUM_SRC; s++) begin
         // Strict compare keeps the lower index on a tie
         if (request_flags_first[s] && request_enables_first[s] &&
             {1'b0, prio[s]} > CPU_LEVEL &&
             (!next_pending.valid ||
              prio[s] > next_pending.level[2:0])) begin
            next_pending.valid = 1'b1;
            next_pending.vector = irq_ctrl_pkg::FIRST_USER_VECTOR + 7'(s);
            next_pending.level = {1'b0, prio[s]};
         end
      end
   end

   // A registered copy; the core sees it one cycle after the cause
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         pending_vector_status <= '0;
      end else begin
         pending_vector_status <= next_pending;
      end
   end

   assign PENDING = pending_vector_status;

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   always_comb begin
      next_rdata = '0;
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         irq_ctrl_pkg::ADDR_CPU_STATUS_WORD:
            next_rdata[irq_ctrl_pkg::CPU_LEVEL_LSB +: 3] = cpu_priority_level;
         irq_ctrl_pkg::ADDR_CORE_CONTROL:
            next_rdata[irq_ctrl_pkg::CPU_TOP_BIT] = cpu_priority_top_bit;
         irq_ctrl_pkg::ADDR_INT_CONTROL_ONE:
            next_rdata[15:0] = interrupt_control_one;
         irq_ctrl_pkg::ADDR_INT_CONTROL_TWO:
            next_rdata[15:0] = interrupt_control_two;
         irq_ctrl_pkg::ADDR_REQ_FLAGS_FIRST:
            next_rdata[NUM_SRC-1:0] = request_flags_first;
         irq_ctrl_pkg::ADDR_REQ_ENABLES_FIRST:
            next_rdata[NUM_SRC-1:0] = request_enables_first;
         irq_ctrl_pkg::ADDR_PENDING_VECTOR_STATUS: begin
            next_rdata[6:0] = pending_vector_status.vector;
            next_rdata[11:8] = pending_vector_status.level;
         end
         default: begin
            rd_hit = 1'b0;
            for (int s = 0; s < NUM_SRC; s++) begin
               if (S_AXI_ARADDR == irq_ctrl_pkg::ADDR_REQ_PRIO_BASE +
                   8'((s / irq_ctrl_pkg::SRC_PER_PRIO_REG) * 4)) begin
                  rd_hit = 1'b1;
                  next_rdata[(s % irq_ctrl_pkg::SRC_PER_PRIO_REG) *
                             irq_ctrl_pkg::PRIO_SLOT +: 3] = prio[s];
               end
            end
         end
      endcase
   end

   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // Read data held until the master takes it
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= irq_ctrl_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= next_rdata;
         S_AXI_RRESP <= rd_hit ? irq_ctrl_pkg::RESP_OKAY
                               : irq_ctrl_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule // irq_priority_ctrl
`default_nettype wire

// ### verification/irq_ctrl_asserts.sv
// Checker: bus and priority assertions for the interrupt block
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_asserts #(
   parameter int NUM_SRC = 16
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire irq_ctrl_pkg::trap_events_t TRAP_EVENT,
   input wire logic CORE_TRAP_ENTER,
   input wire irq_ctrl_pkg::pending_t PENDING,
   input wire logic [3:0] CPU_LEVEL,
   input wire logic TRAP_PENDING
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // Top bit seen on two edges, so the registered offer has caught up
   sequence s_top_held; CPU_LEVEL[3] [*2]; endsequence
   property p_bvalid_stands; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
   a_bvalid_stands: assert property (p_bvalid_stands) else $error("write answer dropped");
   property p_rdata_stands; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("read answer moved");
   property p_top_blocks; s_top_held |-> !PENDING.valid; endproperty
   a_top_blocks: assert property (p_top_blocks) else $error("user offer at top level");
   property p_vector_range; PENDING.valid |-> PENDING.vector >= 7'h08 && PENDING.vector < 7'(8 + NUM_SRC); endproperty
   a_vector_range: assert property (p_vector_range) else $error("vector out of range");
   property p_level_legal; PENDING.valid |-> PENDING.level inside {[4'h1:4'h7]}; endproperty
   a_level_legal: assert property (p_level_legal) else $error("offer level illegal");
   property p_trap_sets; TRAP_EVENT.address_fault |=> TRAP_PENDING; endproperty
   a_trap_sets: assert property (p_trap_sets) else $error("trap status not set");
   property p_trap_enter; CORE_TRAP_ENTER |=> CPU_LEVEL[3]; endproperty
   a_trap_enter: assert property (p_trap_enter) else $error("top bit not set");
   property p_top_no_self_set; !CORE_TRAP_ENTER && !CPU_LEVEL[3] |=> !CPU_LEVEL[3]; endproperty
   a_top_no_self_set: assert property (p_top_no_self_set) else $error("top bit set alone");
endmodule // irq_ctrl_asserts
bind irq_priority_ctrl irq_ctrl_asserts #(.NUM_SRC(NUM_SRC)) u_asserts (.CLK_SYS, .RST_N,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
   .TRAP_EVENT, .CORE_TRAP_ENTER, .PENDING, .CPU_LEVEL, .TRAP_PENDING);
`default_nettype wire

// ### verification/core_model.sv
// Core model: takes the offered interrupt after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module core_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ack_enable,
   input wire logic [3:0] ack_delay,
   input wire irq_ctrl_pkg::pending_t pending,
   output logic core_ack
);
   logic [3:0] wait_count;
   // Restart after each take: the offer lingers one cycle, so delay >= 1
   always_ff @(posedge clk_sys) begin
      if (!rst_n || core_ack || !pending.valid || !ack_enable) begin
         wait_count <= 4'h0;
         core_ack <= 1'b0;
      end else if (wait_count == ack_delay) begin
         core_ack <= 1'b1;
      end else begin
         wait_count <= wait_count + 4'h1;
      end
   end
endmodule // core_model
`default_nettype wire

// ### verification/testbench.sv
// Testbench: register, request, priority and trap scenarios
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin logic [33:0] ev; ev = (e); cmp_count++; if ((g) !== ev) begin mismatches++; $display("ERROR %0t got %h exp %h", $time, (g), ev); end end
module testbench;
   localparam logic [7:0] sw = irq_ctrl_pkg::ADDR_CPU_STATUS_WORD;
   localparam logic [7:0] cc = irq_ctrl_pkg::ADDR_CORE_CONTROL;
   localparam logic [7:0] c1 = irq_ctrl_pkg::ADDR_INT_CONTROL_ONE;
   localparam logic [7:0] c2 = irq_ctrl_pkg::ADDR_INT_CONTROL_TWO;
   localparam logic [7:0] fl = irq_ctrl_pkg::ADDR_REQ_FLAGS_FIRST;
   localparam logic [7:0] en = irq_ctrl_pkg::ADDR_REQ_ENABLES_FIRST;
   localparam logic [7:0] pv = irq_ctrl_pkg::ADDR_PENDING_VECTOR_STATUS;
   localparam logic [1:0] ok = irq_ctrl_pkg::RESP_OKAY;
   localparam logic [1:0] er = irq_ctrl_pkg::RESP_SLVERR;
   logic clk_sys = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic arvalid = 1'b0, core_trap_enter = 1'b0, ack_enable = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [15:0] src_req = 16'h0000, lfsr = 16'h001C;
   logic [4:0] ext_pin = 5'h00, ext_edge;
   logic [3:0] ack_delay = 4'h3, cpu_level;
   logic [1:0] bresp, rresp;
   logic awready, wready, arready, bvalid, rvalid, alt_vector, trap_pending, core_ack;
   irq_ctrl_pkg::trap_events_t trap_event = '0;
   irq_ctrl_pkg::pending_t pending;
   logic [33:0] expect_q[$];
   int mismatches = 0, cmp_count = 0;
   int pos[10] = '{14, 13, 12, 11, 7, 6, 5, 3, 2, 1};
   irq_priority_ctrl #(.NUM_SRC(16)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1), .SRC_REQ(src_req),
      .EXT_PIN(ext_pin), .TRAP_EVENT(trap_event), .CORE_ACK(core_ack),
      .CORE_TRAP_ENTER(core_trap_enter), .PENDING(pending), .CPU_LEVEL(cpu_level),
      .ALT_VECTOR(alt_vector), .TRAP_PENDING(trap_pending), .EXT_EDGE(ext_edge));
   core_model core (.clk_sys, .rst_n, .ack_enable, .ack_delay, .pending, .core_ack);
   // ****************************************************************
   // Clock, monitor and bus tasks
   // ****************************************************************
   initial forever #4 clk_sys = ~clk_sys;
   // Answers are sampled mid-cycle, where registered outputs are settled
   always @(negedge clk_sys) begin
      if (bvalid) `CHK({bresp, 32'h0000_0000}, expect_q.pop_front())
      if (rvalid) `CHK({rresp, rdata}, expect_q.pop_front())
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Ready sampled at the falling edge holds to the next rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
      logic ta, tw;
      logic tb = 1'b0;
      expect_q.push_back({r, 32'h0000_0000});
      @(posedge clk_sys);
      {awaddr, wdata, awvalid, wvalid} <= {a, 16'h0000, d, 2'b11};
      while (!tb) begin
         @(negedge clk_sys);
         {ta, tw, tb} = {awvalid && awready, wvalid && wready, bvalid};
         @(posedge clk_sys);
         {awvalid, wvalid} <= {awvalid && !ta, wvalid && !tw};
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
      logic ta;
      logic tr = 1'b0;
      expect_q.push_back({r, 16'h0000, d});
      @(posedge clk_sys);
      {araddr, arvalid} <= {a, 1'b1};
      while (!tr) begin
         @(negedge clk_sys);
         {ta, tr} = {arvalid && arready, rvalid};
         @(posedge clk_sys);
         arvalid <= arvalid && !ta;
      end
   endtask
   task automatic pulse(input logic [15:0] s, input logic [9:0] t, input logic c);
      @(posedge clk_sys);
      {src_req, trap_event, core_trap_enter} <= {s, t, c};
      @(posedge clk_sys);
      {src_req, trap_event, core_trap_enter} <= 27'h000_0000;
   endtask
   task automatic settle;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles of the run
   initial begin
      #200000;
      mismatches++;
      wrap_up;
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(sw, 16'h0000, ok);
      rd(cc, 16'h0000, ok);
      rd(c1, 16'h0000, ok);
      wr(8'h18, 16'h5050, ok);
      pulse(16'h0008, 10'h000, 1'b0);
      rd(fl, 16'h0008, ok);
      settle;
      `CHK(pending.valid, 1'b0)
      wr(en, 16'h000A, ok);
      settle;
      `CHK(pending, 12'h8B5)
      rd(pv, 16'h050B, ok);
      pulse(16'h0002, 10'h000, 1'b0);
      settle;
      `CHK(pending.vector, 7'h09)
      @(posedge clk_sys);
      ack_enable <= 1'b1;
      repeat (12) @(posedge clk_sys);
      ack_enable <= 1'b0;
      settle;
      `CHK(cpu_level, 4'h5)
      `CHK(pending.valid, 1'b0)
      rd(sw, 16'h00A0, ok);
      wr(c1, 16'h8000, ok);
      wr(sw, 16'h0000, ok);
      rd(sw, 16'h00A0, ok);
      wr(c1, 16'h0000, ok);
      wr(sw, 16'h0000, ok);
      settle;
      `CHK(pending.valid, 1'b1)
      wr(cc, 16'h0008, ok);
      rd(cc, 16'h0000, ok);
      pulse(16'h0000, 10'h000, 1'b1);
      settle;
      `CHK(cpu_level, 4'h8)
      `CHK(pending.valid, 1'b0)
      wr(cc, 16'h0000, ok);
      wr(fl, 16'h0000, ok);
      wr(c1, 16'h0700, ok);
      for (int i = 0; i < 10; i++) begin
         pulse(16'h0000, 10'h200 >> i, 1'b0);
         settle;
         `CHK(trap_pending, 1'b1)
         rd(c1, 16'h0700 | (16'h0001 << pos[i]) | (i < 6 ? 16'h0010 : 16'h0000), ok);
         wr(c1, 16'h0700, ok);
      end
      wr(c1, 16'h0000, ok);
      pulse(16'h0000, 10'h200, 1'b0);
      settle;
      `CHK(trap_pending, 1'b0)
      for (int k = 0; k < 2; k++) begin
         wr(c2, 16'h8000 | 16'(k), ok);
         @(posedge clk_sys);
         ext_pin <= (k == 0) ? 5'h01 : 5'h00;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         `CHK(ext_edge, 5'h01)
         settle;
         `CHK(alt_vector, 1'b1)
      end
      rd(fl, 16'h0001, ok);
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         wr(en, lfsr, ok);
         rd(en, lfsr, ok);
      end
      wr(8'h3C, 16'hFFFF, er);
      rd(8'h3C, 16'h0000, er);
      wr(pv, 16'h0000, er);
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
